/* rtl/ccv_map.vh */
`ifndef CCV_MAP_VH
`define CCV_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCV_OFS_CTRL     8'h00
`define CCV_OFS_CMD      8'h04
`define CCV_OFS_CTX      8'h08
`define CCV_OFS_DATA0    8'h0C
`define CCV_OFS_DATA1    8'h10
`define CCV_OFS_DATA2    8'h14
`define CCV_OFS_STATUS   8'h18
`define CCV_OFS_CFG      8'h1C
`define CCV_OFS_FAILCNT  8'h20
`define CCV_OFS_CAPS     8'h24

// ----------------------------------------
// context register bit positions
// ----------------------------------------
`define CCV_CTX_PROTO    0
`define CCV_CTX_APP      1
`define CCV_CTX_AUTH     2
`define CCV_CTX_MASTER   3
`define CCV_CTX_CHAIN    4
`define CCV_CTX_MAC_OK   5
`define CCV_CTX_CRYPT_OK 6
`define CCV_CTX_NVM_FAIL 7

// ----------------------------------------
// command and option codes
// ----------------------------------------
`define CCV_CMD_CONFIG   8'h5C
`define CCV_CMD_VERSION  8'h60
`define CCV_CMD_MORE     8'hAF
`define CCV_OPT_CARD     8'h00
`define CCV_OPT_SM       8'h04
`define CCV_OPT_CAPS     8'h05
`define CCV_OPT_TAMPER   8'h07
`define CCV_OPT_FAIL     8'h0A
`define CCV_OPT_MOD      8'h0B

// ----------------------------------------
// option data lengths and field masks
// ----------------------------------------
`define CCV_LEN_CARD     4'h1
`define CCV_LEN_SM       4'h2
`define CCV_LEN_CAPS     4'hA
`define CCV_LEN_TAMPER   4'h2
`define CCV_LEN_FAIL     4'h5
`define CCV_LEN_MOD      4'h1
`define CCV_LEN_NONE     4'h0
`define CCV_CARD_RSVD    8'hFD
`define CCV_KEY_MAX      8'h04
`define CCV_KEY_FREE     8'h0E
`define CCV_KEY_NONE     8'h0F

// ----------------------------------------
// status codes and defaults
// ----------------------------------------
`define CCV_SW1          8'h91
`define CCV_ST_OK        8'h00
`define CCV_ST_MORE      8'hAF
`define CCV_ST_LENGTH    8'h7E
`define CCV_ST_PARAM     8'h9E
`define CCV_ST_AUTH      8'hAE
`define CCV_ST_PERM      8'h9D
`define CCV_ST_ABORT     8'hCA
`define CCV_ST_INTEG     8'h1E
`define CCV_ST_MEMORY    8'hEE
`define CCV_ST_ILLEGAL   8'h1C
`define CCV_DEF_LIMIT    16'h03E8
`define CCV_DEF_DECR     16'h000A
`define CCV_PART_LAST    2'h2
`define CCV_RESP_OKAY    2'h0
`define CCV_RESP_SLVERR  2'h2

`endif

/* rtl/ccv_top.v */
`timescale 1ns/10ps
`include "ccv_map.vh"

module ccv_top #(
   parameter AW = 8
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   output reg           leakage_resilient_mode,
   output reg           tamper_detect_enable,
   output reg           strong_back_modulation,
   output reg           failed_count_enable,
   output reg           cmd_done
);

// ----------------------------------------
// storage
// ----------------------------------------
reg  [7:0]    cmd_code;
reg  [7:0]    cmd_opt;
reg  [3:0]    cmd_len;
reg  [7:0]    ctx;
reg  [31:0]   data0;
reg  [31:0]   data1;
reg  [15:0]   data2;
reg           go;
reg  [15:0]   resp_sw;
reg           resp_done;
reg  [1:0]    ver_part;
reg           random_id;
reg           sm_chain_off;
reg  [7:0]    tamper_status_key_select;
reg  [15:0]   failed_count_limit;
reg  [15:0]   failed_count_decrement;
reg  [7:0]    cap_byte5;
reg  [7:0]    cap_byte6;

reg           aw_full;
reg           w_full;
reg  [AW-1:0] waddr;
reg  [31:0]   wdat;
reg  [3:0]    wstb;

wire [79:0]   dbytes = {data2, data1, data0};
wire [7:0]    b0 = dbytes[7:0];
wire [7:0]    b1 = dbytes[15:8];
wire [7:0]    b2 = dbytes[23:16];
wire [7:0]    b3 = dbytes[31:24];
wire [7:0]    b4 = dbytes[39:32];
wire [7:0]    b8 = dbytes[71:64];
wire [7:0]    b9 = dbytes[79:72];

// ----------------------------------------
// register read mux
// ----------------------------------------
function [32:0] reg_read;
   input [AW-1:0] a;
   begin
      reg_read = 33'h0;
      case (a[7:0])
         `CCV_OFS_CTRL:    reg_read = {1'b1, 32'h0};
         `CCV_OFS_CMD:     reg_read = {1'b1, 12'h0, cmd_len,
                                       cmd_opt, cmd_code};
         `CCV_OFS_CTX:     reg_read = {1'b1, 24'h0, ctx};
         `CCV_OFS_DATA0:   reg_read = {1'b1, data0};
         `CCV_OFS_DATA1:   reg_read = {1'b1, data1};
         `CCV_OFS_DATA2:   reg_read = {1'b1, 16'h0, data2};
         `CCV_OFS_STATUS:  reg_read = {1'b1, 13'h0, ver_part,
                                       resp_done, resp_sw};
         `CCV_OFS_CFG:     reg_read = {1'b1, 16'h0,
                                       tamper_status_key_select,
                                       2'h0, sm_chain_off, random_id,
                                       strong_back_modulation,
                                       failed_count_enable,
                                       tamper_detect_enable,
                                       leakage_resilient_mode};
         `CCV_OFS_FAILCNT: reg_read = {1'b1, failed_count_decrement,
                                       failed_count_limit};
         `CCV_OFS_CAPS:    reg_read = {1'b1, 16'h0, cap_byte6,
                                       cap_byte5};
         default:          reg_read = 33'h0;
      endcase
      if (a[AW-1:0] != {a[AW-1:2], 2'b00})
         reg_read = 33'h0;
   end
endfunction

// ----------------------------------------
// write channel
// ----------------------------------------
wire [32:0] wr_old  = reg_read(waddr);
wire [31:0] wmask   = {{8{wstb[3]}}, {8{wstb[2]}},
                       {8{wstb[1]}}, {8{wstb[0]}}};
wire [31:0] wmerged = (wr_old[31:0] & ~wmask) | (wdat & wmask);
wire        wr_fire = aw_full & w_full & ~s_axi_bvalid;

assign s_axi_awready = ~aw_full;
assign s_axi_wready  = ~w_full;

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      waddr        <= {AW{1'b0}};
      wdat         <= 32'h0;
      wstb         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CCV_RESP_OKAY;
      cmd_code     <= 8'h00;
      cmd_opt      <= 8'h00;
      cmd_len      <= 4'h0;
      ctx          <= 8'h00;
      data0        <= 32'h0;
      data1        <= 32'h0;
      data2        <= 16'h0;
      go           <= 1'b0;
   end
   else
   begin
      go <= 1'b0;
      if (s_axi_awvalid && !aw_full)
      begin
         aw_full <= 1'b1;
         waddr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full)
      begin
         w_full <= 1'b1;
         wdat   <= s_axi_wdata;
         wstb   <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
         aw_full      <= 1'b0;
         w_full       <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_old[32] ? `CCV_RESP_OKAY : `CCV_RESP_SLVERR;
         case (waddr[7:0])
            `CCV_OFS_CTRL:  go <= wdat[0] & wstb[0];
            `CCV_OFS_CMD:
            begin
               cmd_code <= wmerged[7:0];
               cmd_opt  <= wmerged[15:8];
               cmd_len  <= wmerged[19:16];
            end
            `CCV_OFS_CTX:   ctx   <= wmerged[7:0];
            `CCV_OFS_DATA0: data0 <= wmerged;
            `CCV_OFS_DATA1: data1 <= wmerged;
            `CCV_OFS_DATA2: data2 <= wmerged[15:0];
            default:        go    <= 1'b0;
         endcase
      end
   end
end

// ----------------------------------------
// read channel
// ----------------------------------------
wire [32:0] rd_val = reg_read(s_axi_araddr);

assign s_axi_arready = ~s_axi_rvalid;

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `CCV_RESP_OKAY;
   end
   else if (s_axi_arvalid && !s_axi_rvalid)
   begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val[31:0];
      s_axi_rresp  <= rd_val[32] ? `CCV_RESP_OKAY : `CCV_RESP_SLVERR;
   end
   else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
end

// ----------------------------------------
// command evaluation
// ----------------------------------------
reg  [3:0] opt_len;
reg        opt_ok;
reg        param_bad;
reg  [7:0] next_code;
reg  [1:0] next_part;

wire proto_on = ctx[`CCV_CTX_PROTO];
wire app_sel  = ctx[`CCV_CTX_APP];
wire auth_on  = ctx[`CCV_CTX_AUTH];
wire master   = ctx[`CCV_CTX_MASTER] & auth_on;
wire chain_on = ctx[`CCV_CTX_CHAIN];
wire mac_ok   = ctx[`CCV_CTX_MAC_OK];
wire crypt_ok = ctx[`CCV_CTX_CRYPT_OK];
wire nvm_fail = ctx[`CCV_CTX_NVM_FAIL];
wire key_ok   = (b1 <= `CCV_KEY_MAX) || (b1 == `CCV_KEY_FREE) ||
                (b1 == `CCV_KEY_NONE);

always @*
begin
   opt_len   = `CCV_LEN_NONE;
   opt_ok    = 1'b1;
   param_bad = 1'b0;
   case (cmd_opt)
      `CCV_OPT_CARD:
      begin
         opt_len   = `CCV_LEN_CARD;
         param_bad = (b0 & `CCV_CARD_RSVD) != 8'h00;
      end
      `CCV_OPT_SM:     opt_len = `CCV_LEN_SM;
      `CCV_OPT_CAPS:   opt_len = `CCV_LEN_CAPS;
      `CCV_OPT_TAMPER:
      begin
         opt_len   = `CCV_LEN_TAMPER;
         param_bad = ~key_ok;
      end
      `CCV_OPT_FAIL:
      begin
         opt_len   = `CCV_LEN_FAIL;
         param_bad = b0[0] && ({b2, b1} == 16'h0000);
      end
      `CCV_OPT_MOD:    opt_len = `CCV_LEN_MOD;
      default:         opt_ok  = 1'b0;
   endcase
end

always @*
begin
   next_code = `CCV_ST_OK;
   next_part = 2'h0;
   case (cmd_code)
      `CCV_CMD_CONFIG:
      begin
         if (chain_on)
            next_code = `CCV_ST_ABORT;
         else if (!app_sel)
            next_code = `CCV_ST_PERM;
         else if (!master)
            next_code = `CCV_ST_AUTH;
         else if (!opt_ok)
            next_code = `CCV_ST_PARAM;
         else if (cmd_len != opt_len)
            next_code = `CCV_ST_LENGTH;
         else if (param_bad)
            next_code = `CCV_ST_PARAM;
         else if (!mac_ok || !crypt_ok)
            next_code = `CCV_ST_INTEG;
         else if (nvm_fail)
            next_code = `CCV_ST_MEMORY;
      end
      `CCV_CMD_VERSION:
      begin
         if (!proto_on)
            next_code = `CCV_ST_ILLEGAL;
         else if (chain_on)
            next_code = `CCV_ST_ABORT;
         else if (cmd_len != `CCV_LEN_NONE)
            next_code = `CCV_ST_LENGTH;
         else if (auth_on && !mac_ok)
            next_code = `CCV_ST_INTEG;
         else if (nvm_fail)
            next_code = `CCV_ST_MEMORY;
         else
         begin
            next_code = `CCV_ST_MORE;
            next_part = 2'h1;
         end
      end
      `CCV_CMD_MORE:
      begin
         if (ver_part == 2'h0)
            next_code = `CCV_ST_ILLEGAL;
         else if (cmd_len != `CCV_LEN_NONE)
            next_code = `CCV_ST_LENGTH;
         else if (ver_part == `CCV_PART_LAST)
            next_part = 2'h3;
         else
         begin
            next_code = `CCV_ST_MORE;
            next_part = ver_part + 2'h1;
         end
      end
      default: next_code = `CCV_ST_ILLEGAL;
   endcase
end

// ----------------------------------------
// response and stored configuration
// ----------------------------------------
// only this option's defined bits are taken; reserved card-option bits set in b0 fail the command with the parameter status
wire commit = go && (cmd_code == `CCV_CMD_CONFIG) &&
              (next_code == `CCV_ST_OK);

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      resp_sw                  <= 16'h0000;
      resp_done                <= 1'b0;
      cmd_done                 <= 1'b0;
      ver_part                 <= 2'h0;
      leakage_resilient_mode   <= 1'b0;
      tamper_detect_enable     <= 1'b0;
      strong_back_modulation   <= 1'b1;
      failed_count_enable      <= 1'b1;
      random_id                <= 1'b0;
      sm_chain_off             <= 1'b0;
      tamper_status_key_select <= `CCV_KEY_FREE;
      failed_count_limit       <= `CCV_DEF_LIMIT;
      failed_count_decrement   <= `CCV_DEF_DECR;
      cap_byte5                <= 8'h00;
      cap_byte6                <= 8'h00;
   end
   else
   begin
      cmd_done <= go;
      if (go)
      begin
         resp_sw   <= {`CCV_SW1, next_code};
         resp_done <= 1'b1;
         // frame index 3 means the last frame went out; any other
         // command drops a half-read version sequence
         ver_part  <= (next_part == 2'h3) ? 2'h0 : next_part;
      end
      else if (wr_fire && (waddr[7:0] == `CCV_OFS_CTRL) && wstb[0])
         resp_done <= 1'b0;
      if (commit)
      begin
         case (cmd_opt)
            `CCV_OPT_CARD:
               if (b0[1])
                  random_id <= 1'b1;
            `CCV_OPT_SM:
               if (b0[2])
                  sm_chain_off <= 1'b1;
            `CCV_OPT_CAPS:
            begin
               leakage_resilient_mode <= leakage_resilient_mode | b4[1];
               cap_byte5              <= b8;
               cap_byte6              <= b9;
            end
            `CCV_OPT_TAMPER:
            begin
               if (b0[0])
                  tamper_detect_enable <= 1'b1;
               tamper_status_key_select <= b1;
            end
            `CCV_OPT_FAIL:
            begin
               failed_count_enable <= b0[0];
               if (b0[0])
               begin
                  failed_count_limit     <= {b2, b1};
                  failed_count_decrement <= {b4, b3};
               end
            end
            `CCV_OPT_MOD: strong_back_modulation <= b0[0];
            default:      random_id <= random_id;
         endcase
      end
   end
end

endmodule // ccv_top

/* tb/ccv_assertions.sv */
`timescale 1ns/10ps
module ccv_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        leakage_resilient_mode,
   input wire        tamper_detect_enable,
   input wire        strong_back_modulation,
   input wire        failed_count_enable,
   input wire        cmd_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_lrm_keep;
      leakage_resilient_mode |=> leakage_resilient_mode;
   endproperty
   a_lrm_keep: assert property (p_lrm_keep) else $error("lrm dropped");
   property p_tam_keep;
      tamper_detect_enable |=> tamper_detect_enable;
   endproperty
   a_tam_keep: assert property (p_tam_keep) else $error("tamper off");
   property p_str_cause;
      $past(aresetn) && $changed(strong_back_modulation) |-> cmd_done;
   endproperty
   a_str_cause: assert property (p_str_cause) else $error("strong");
   property p_fce_cause;
      $past(aresetn) && $changed(failed_count_enable) |-> cmd_done;
   endproperty
   a_fce_cause: assert property (p_fce_cause) else $error("fce");
   property p_done_pulse;
      cmd_done |=> !cmd_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done");
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("b dropped");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("r dropped");
   property p_b_release;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_release: assert property (p_b_release) else $error("b kept");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("no r");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
         !s_axi_bvalid |-> ##2 s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("no b");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_lrm: cover property ($rose(leakage_resilient_mode));
   c_std: cover property ($fell(strong_back_modulation));
endmodule // ccv_checker

bind ccv_top ccv_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .leakage_resilient_mode(leakage_resilient_mode),
   .tamper_detect_enable(tamper_detect_enable),
   .strong_back_modulation(strong_back_modulation),
   .failed_count_enable(failed_count_enable), .cmd_done(cmd_done));

/* tb/ccv_reader.sv */
`timescale 1ns/10ps
`include "ccv_map.vh"
module ccv_reader (
   input  wire        aclk,
   output reg  [7:0]  awaddr,
   output reg         awvalid,
   input  wire        awready,
   output reg  [31:0] wdata,
   output reg  [3:0]  wstrb,
   output reg         wvalid,
   input  wire        wready,
   input  wire [1:0]  bresp,
   input  wire        bvalid,
   output reg         bready,
   output reg  [7:0]  araddr,
   output reg         arvalid,
   input  wire        arready,
   input  wire [31:0] rdata,
   input  wire [1:0]  rresp,
   input  wire        rvalid,
   output reg         rready
);
   // extra cycles before accepting an answer, to stretch valid
   integer slow;
   initial
   begin
      slow = 0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 0;
      {araddr, arvalid, rready} = 0;
   end

   task wr(input [7:0] a, input [31:0] d, output [1:0] r);
      reg ad;
      reg wd;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         wstrb <= 4'hF;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         ad = 1'b0;
         wd = 1'b0;
         while (!(ad && wd))
         begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
               ad = 1'b1;
               awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
               wd = 1'b1;
               wvalid <= 1'b0;
            end
         end
         while (!bvalid)
            @(posedge aclk);
         repeat (slow)
            @(posedge aclk);
         bready <= 1'b1;
         @(posedge aclk);
         r = bresp;
         bready <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         @(posedge aclk);
         while (!arready)
            @(posedge aclk);
         arvalid <= 1'b0;
         while (!rvalid)
            @(posedge aclk);
         repeat (slow)
            @(posedge aclk);
         rready <= 1'b1;
         @(posedge aclk);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask

   task run_cmd(input [7:0] c, input [7:0] o, input [3:0] l,
      input [7:0] x, input [31:0] d0, input [31:0] d1, output [31:0] st);
      reg [1:0] r;
      begin
         wr(`CCV_OFS_CMD, {12'h000, l, o, c}, r);
         wr(`CCV_OFS_CTX, {24'h000000, x}, r);
         wr(`CCV_OFS_DATA0, d0, r);
         wr(`CCV_OFS_DATA1, d1, r);
         wr(`CCV_OFS_CTRL, 32'h00000001, r);
         st = 32'h00000000;
         while (!st[16])
            rd(`CCV_OFS_STATUS, st, r);
      end
   endtask
endmodule // ccv_reader

/* tb/test_config_and_version_commands.sv */
`timescale 1ns/10ps
`include "ccv_map.vh"
module test_config_and_version_commands;
   typedef struct packed {
      logic [7:0]  c;
      logic [7:0]  o;
      logic [3:0]  l;
      logic [7:0]  x;
      logic [31:0] d0;
      logic [31:0] d1;
      logic [7:0]  s;
      logic [1:0]  i;
      logic [3:0]  u;
   } ccv_row_t;
   reg          aclk;
   reg          aresetn;
   wire [7:0]   awaddr, araddr;
   wire [31:0]  wdata, rdata;
   wire [3:0]   wstrb;
   wire [1:0]   bresp, rresp;
   wire         awvalid, awready, wvalid, wready, bvalid, bready;
   wire         arvalid, arready, rvalid, rready;
   wire         lrm, tam, stm, fce;
   integer      err_count, total_checks, n;
   ccv_row_t    rows[$];
   reg  [31:0]  v;
   reg  [1:0]   r;

   ccv_top #(.AW(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .leakage_resilient_mode(lrm),
      .tamper_detect_enable(tam), .strong_back_modulation(stm),
      .failed_count_enable(fce), .cmd_done());
   ccv_reader i_rdr (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial
   begin
      aclk = 1'b0;
      forever
         #5 aclk = ~aclk;
   end

   task check(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
         end
      end
   endtask

   task add(input [7:0] c, input [7:0] o, input [3:0] l, input [7:0] x,
      input [31:0] d0, input [31:0] d1, input [7:0] s, input [1:0] i,
      input [3:0] u);
      begin
         rows.push_back({c, o, l, x, d0, d1, s, i, u});
      end
   endtask

   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task defaults;
      begin
         check({28'h0000000, lrm, tam, stm, fce}, 32'h00000003);
         i_rdr.rd(`CCV_OFS_FAILCNT, v, r);
         check(v, 32'h000A03E8);
         i_rdr.rd(`CCV_OFS_CFG, v, r);
         check(v, 32'h00000E0C);
         $display("defaults done");
      end
   endtask

   initial
   begin
      #200000;
      err_count = err_count + 1;
      report_and_stop;
   end

   initial
   begin
      err_count = 0;
      total_checks = 0;
      aresetn = 1'b0;
      add(8'h5C, 8'h0B, 4'h1, 8'h7F, 0, 0, 8'hCA, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'h6D, 0, 0, 8'h9D, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'h67, 0, 0, 8'hAE, 2'h0, 4'h3);
      add(8'h5C, 8'h03, 4'h1, 8'h6F, 0, 0, 8'h9E, 2'h0, 4'h3);
      add(8'h5C, 8'h00, 4'h2, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h04, 4'h1, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h05, 4'h9, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h07, 4'h1, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h0A, 4'h4, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h2, 8'h6F, 0, 0, 8'h7E, 2'h0, 4'h3);
      add(8'h5C, 8'h00, 4'h1, 8'h6F, 1, 0, 8'h9E, 2'h0, 4'h3);
      add(8'h5C, 8'h07, 4'h2, 8'h6F, 'h501, 0, 8'h9E, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'h4F, 0, 0, 8'h1E, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'h2F, 0, 0, 8'h1E, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'hEF, 0, 0, 8'hEE, 2'h0, 4'h3);
      add(8'h5C, 8'h0A, 4'h5, 8'h6F, 1, 0, 8'h9E, 2'h0, 4'h3);
      add(8'h5C, 8'h0B, 4'h1, 8'h6F, 'hFE, 0, 8'h00, 2'h0, 4'h1);
      add(8'h5C, 8'h0B, 4'h1, 8'h6F, 1, 0, 8'h00, 2'h0, 4'h3);
      add(8'h5C, 8'h07, 4'h2, 8'h6F, 'hF00, 0, 8'h00, 2'h0, 4'h3);
      add(8'h5C, 8'h07, 4'h2, 8'h6F, 'h401, 0, 8'h00, 2'h0, 4'h7);
      add(8'h5C, 8'h07, 4'h2, 8'h6F, 'hE00, 0, 8'h00, 2'h0, 4'h7);
      add(8'h5C, 8'h05, 4'hA, 8'h6F, 0, 2, 8'h00, 2'h0, 4'hF);
      add(8'h5C, 8'h05, 4'hA, 8'h6F, 0, 0, 8'h00, 2'h0, 4'hF);
      add(8'h5C, 8'h0A, 4'h5, 8'h6F, 0, 0, 8'h00, 2'h0, 4'hE);
      add(8'h5C, 8'h0A, 4'h5, 8'h6F, 'h5123401, 0, 8'h00, 2'h0, 4'hF);
      add(8'h5C, 8'h00, 4'h1, 8'h6F, 2, 0, 8'h00, 2'h0, 4'hF);
      add(8'h5C, 8'h04, 4'h2, 8'h6F, 4, 0, 8'h00, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h0, 8'h02, 0, 0, 8'h1C, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h0, 8'h03, 0, 0, 8'hAF, 2'h1, 4'hF);
      add(8'hAF, 8'h00, 4'h0, 8'h03, 0, 0, 8'hAF, 2'h2, 4'hF);
      add(8'hAF, 8'h00, 4'h0, 8'h03, 0, 0, 8'h00, 2'h0, 4'hF);
      add(8'hAF, 8'h00, 4'h0, 8'h03, 0, 0, 8'h1C, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h1, 8'h03, 0, 0, 8'h7E, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h0, 8'h13, 0, 0, 8'hCA, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h0, 8'h07, 0, 0, 8'h1E, 2'h0, 4'hF);
      add(8'h60, 8'h00, 4'h0, 8'h83, 0, 0, 8'hEE, 2'h0, 4'hF);
      add(8'h11, 8'h00, 4'h0, 8'h6F, 0, 0, 8'h1C, 2'h0, 4'hF);
      repeat (12)
         @(posedge aclk);
      aresetn <= 1'b1;
      defaults;
      for (n = 0; n < rows.size(); n = n + 1)
      begin
         i_rdr.run_cmd(rows[n].c, rows[n].o, rows[n].l, rows[n].x,
            rows[n].d0, rows[n].d1, v);
         check(v, {13'h0, rows[n].i, 1'b1, 8'h91, rows[n].s});
         check({lrm, tam, stm, fce}, rows[n].u);
         $display("row %0d done", n);
      end
      i_rdr.rd(`CCV_OFS_FAILCNT, v, r);
      check(v, 32'h00051234);
      i_rdr.wr(`CCV_OFS_CFG, 32'h00000000, r);
      check({30'h0, r}, 32'h00000000);
      i_rdr.slow = 4;
      i_rdr.rd(`CCV_OFS_CFG, v, r);
      check(v, 32'h00000E3F);
      i_rdr.slow = 0;
      i_rdr.wr(8'h40, 32'h00000001, r);
      check({30'h0, r}, 32'h00000002);
      i_rdr.rd(8'h40, v, r);
      check({r, v[29:0]}, 32'h80000000);
      $display("bus tests done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12)
         @(posedge aclk);
      aresetn <= 1'b1;
      defaults;
      report_and_stop;
   end
endmodule // test_config_and_version_commands
